// >>> common/ops_pkg.sv
// Purpose: shared constants and types for the output pin select block
// Assumes: registers reached over AHB-Lite, one 32-bit word per register
// Notes:   printed offsets are register indexes; byte address = index * 4
`default_nettype none

package ops_pkg;

    // ==================================================================
    // register map
    localparam int unsigned      IDX_W         = 12;
    localparam logic [11:0]      IDX_TERM      = 12'h461;
    localparam logic [11:0]      IDX_LED_SRC   = 12'h462;
    localparam logic [11:0]      IDX_CLK_SRC   = 12'h463;
    localparam int unsigned      IDX_LSB       = 2;  // word aligned
    localparam int unsigned      IDX_MSB       = 13;
    localparam logic [1:0]       HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0]       HRESP_OKAY    = 2'h0;

    // ==================================================================
    // reset values and writable bits
    localparam logic [15:0]      TERM_RST      = 16'h0410;
    localparam logic [15:0]      TERM_RW_MASK  = 16'hFFFF;
    localparam logic [15:0]      LED_RST       = 16'h0000;
    localparam logic [15:0]      LED_RW_MASK   = 16'h7777;
    localparam logic [15:0]      CLK_RST       = 16'h0001;
    localparam logic [15:0]      CLK_RW_MASK   = 16'h00F7;

    // ==================================================================
    // field positions
    localparam int unsigned      TERM_LSB      = 1;
    localparam int unsigned      TERM_MSB      = 4;
    localparam int unsigned      LED0_SRC_LSB  = 0;
    localparam int unsigned      LED0_CLK_LSB  = 4;
    localparam int unsigned      LED1_SRC_LSB  = 8;
    localparam int unsigned      LED1_CLK_LSB  = 12;
    localparam int unsigned      CKO_SRC_LSB   = 0;
    localparam int unsigned      CKO_CLK_LSB   = 4;

    // ==================================================================
    // source and clock encodings
    typedef enum logic [2:0] {
        OPS_SRC_FUNC,
        OPS_SRC_CLOCK,
        OPS_SRC_WAKE,
        OPS_SRC_UNDERVOLT,
        OPS_SRC_TS_TX,
        OPS_SRC_TS_RX,
        OPS_SRC_LOW,
        OPS_SRC_HIGH
    } ops_src_t;

    localparam logic [3:0]       CLK_SEL_CRYSTAL = 4'h0;
    localparam logic [3:0]       CLK_SEL_TXLINE  = 4'h1;

    // ==================================================================
    // carriers and state
    typedef struct packed {
        logic crystal_input_clock;
        logic transmit_line_clock;
        logic wake_indication;
        logic undervolt_indication;
        logic ts_tx_pulse;
        logic ts_rx_pulse;
    } ops_sources_t;

    typedef struct packed {
        logic [15:0] term;
        logic [15:0] led_src;
        logic [15:0] clk_src;
    } ops_regs_t;

    typedef struct packed {
        ops_regs_t        regs;
        logic             dp_valid;
        logic             dp_write;
        logic [IDX_W-1:0] dp_index;
        logic [31:0]      hrdata;
    } ops_top_state_t;

    typedef struct packed {
        ops_sources_t stage1;
        ops_sources_t stage2;
    } ops_sync_state_t;

endpackage

`default_nettype wire

// >>> dv/ops_src_model.sv
// Purpose: far-side clock sources for the routed clock paths
// Assumes: both clocks free-running, slow against clk_sys
// Notes:   periods 8 and 12 cycles so the two are told apart
`default_nettype none

module ops_src_model (
    input  wire logic clk_sys,
    input  wire logic resetn,
    output var  logic crystal_input_clock,
    output var  logic transmit_line_clock
);
    logic [3:0] cnt;

    // both clocks from one counter, changed just after the edge
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            cnt                 <= 4'h0;
            crystal_input_clock <= 1'b0;
            transmit_line_clock <= 1'b0;
        end
        else
        begin
            cnt <= (cnt == 4'hB) ? 4'h0 : cnt + 4'h1;
            if (cnt[1:0] == 2'h3) crystal_input_clock <= !crystal_input_clock;
            if (cnt == 4'h5 || cnt == 4'hB)
                transmit_line_clock <= !transmit_line_clock;
        end
    end
endmodule

`default_nettype wire

// >>> dv/ops_top_sva.sv
// Purpose: port checks for the output pin select block
// Assumes: register contents shadowed from bus writes seen at the ports
// Notes:   async sources reach a pin three edges after they are sampled
`default_nettype none

module ops_top_sva (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    input  wire logic        crystal_input_clock,
    input  wire logic        wake_indication,
    input  wire logic        first_indicator_function,
    input  wire logic        second_indicator_function,
    input  wire logic        first_indicator_pin,
    input  wire logic        second_indicator_pin,
    input  wire logic        clock_output_pin,
    input  wire logic [3:0]  rx_term_step
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    // ==========================================================
    // shadow registers
    logic        dp_wr;
    logic [11:0] dp_ix;
    logic [15:0] sh_t;
    logic [15:0] sh_l;
    logic [15:0] sh_c;
    logic [15:0] rd_v;
    wire  logic  hit  = haddr[31:14] == 18'h0 && haddr[1:0] == 2'h0;
    wire  logic  take = hsel && hready && htrans == ops_pkg::HTRANS_NONSEQ;

    // writes land at the end of the data phase, as in the design
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            dp_wr <= 1'b0;
            dp_ix <= 12'h000;
            sh_t  <= 16'h0410;
            sh_l  <= 16'h0000;
            sh_c  <= 16'h0001;
        end
        else
        begin
            dp_wr <= take && hwrite && hit;
            dp_ix <= haddr[13:2];
            if (dp_wr && dp_ix == ops_pkg::IDX_TERM) sh_t <= hwdata[15:0];
            if (dp_wr && dp_ix == ops_pkg::IDX_LED_SRC)
                sh_l <= hwdata[15:0] & 16'h7777;
            if (dp_wr && dp_ix == ops_pkg::IDX_CLK_SRC)
                sh_c <= hwdata[15:0] & 16'h00F7;
        end
    end

    // expected read word for the address now on the bus
    always_comb
    begin
        rd_v = 16'h0000;
        if (hit && haddr[13:2] == ops_pkg::IDX_TERM) rd_v = sh_t;
        if (hit && haddr[13:2] == ops_pkg::IDX_LED_SRC) rd_v = sh_l;
        if (hit && haddr[13:2] == ops_pkg::IDX_CLK_SRC) rd_v = sh_c;
    end

    // ==========================================================
    // properties
    sequence s_rd_take;
        take && !hwrite && !dp_wr;
    endsequence
    sequence s_led0_wake;
        (sh_l[2:0] == 3'h2) [*4];
    endsequence
    sequence s_cko_xtal;
        (sh_c[2:0] == 3'h1 && sh_c[7:4] == 4'h0) [*4];
    endsequence

    a_read_data: assert property (
        s_rd_take |=> hrdata == {16'h0000, $past(rd_v)})
        else $error("read data differs from register");
    a_term_follow: assert property (
        rx_term_step == sh_t[4:1])
        else $error("termination step differs from field");
    a_led0_func: assert property (
        sh_l[2:0] == 3'h0 |=>
            first_indicator_pin == $past(first_indicator_function))
        else $error("first pin not on its function");
    a_led0_low: assert property (
        sh_l[2:0] == 3'h6 |=> !first_indicator_pin)
        else $error("first pin not low");
    a_led1_func: assert property (
        sh_l[10:8] == 3'h0 |=>
            second_indicator_pin == $past(second_indicator_function))
        else $error("second pin not on its function");
    a_led1_high: assert property (
        sh_l[10:8] == 3'h7 |=> second_indicator_pin)
        else $error("second pin not high");
    a_led0_wake: assert property (
        s_led0_wake |-> first_indicator_pin == $past(wake_indication, 3))
        else $error("first pin not on wake");
    a_cko_xtal: assert property (
        s_cko_xtal |-> clock_output_pin == $past(crystal_input_clock, 3))
        else $error("clock pin not on crystal clock");
    a_cko_low: assert property (
        sh_c[2:0] == 3'h6 |=> !clock_output_pin)
        else $error("clock pin not low");
endmodule

bind ops_top ops_top_sva u_ops_top_sva (
    .clk_sys, .resetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready,
    .hrdata, .crystal_input_clock, .wake_indication,
    .first_indicator_function, .second_indicator_function,
    .first_indicator_pin, .second_indicator_pin, .clock_output_pin,
    .rx_term_step
);

`default_nettype wire

// >>> dv/ops_top_tb.sv
// Purpose: self-checking bench for the output pin select block
// Assumes: zero-wait AHB-Lite slave, hready fed back from hreadyout
// Notes:   pins sampled on the falling edge, inputs moved on the rising
`default_nettype none

module ops_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [31:0] A_TERM = {18'h0, ops_pkg::IDX_TERM, 2'h0};
    localparam logic [31:0] A_LED  = {18'h0, ops_pkg::IDX_LED_SRC, 2'h0};
    localparam logic [31:0] A_CKO  = {18'h0, ops_pkg::IDX_CLK_SRC, 2'h0};
    localparam logic [31:0] A_NONE = 32'h0000_1190;

    logic        clk_sys;
    logic        resetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        xtal;
    logic        line;
    logic [3:0]  srcs;
    logic [2:0]  func;
    logic [2:0]  pins;
    logic [3:0]  rx_term_step;
    logic [2:0]  hx;
    logic [2:0]  hl;
    logic [31:0] q;
    int          n_fail;
    int          total_checks;

    ops_top u_ops_top (
        .clk_sys, .resetn, .hsel, .haddr, .htrans, .hwrite,
        .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
        .hrdata, .crystal_input_clock(xtal), .transmit_line_clock(line),
        .wake_indication(srcs[3]), .undervolt_indication(srcs[2]),
        .ts_tx_pulse(srcs[1]), .ts_rx_pulse(srcs[0]),
        .first_indicator_function(func[0]),
        .second_indicator_function(func[1]),
        .third_indicator_function(func[2]),
        .first_indicator_pin(pins[0]), .second_indicator_pin(pins[1]),
        .clock_output_pin(pins[2]), .rx_term_step
    );

    ops_src_model u_ops_src_model (
        .clk_sys, .resetn, .crystal_input_clock(xtal),
        .transmit_line_clock(line)
    );

    // clock generation
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // clock history, same sampling as the pin path
    always @(posedge clk_sys)
    begin
        hx <= {hx[1:0], xtal};
        hl <= {hl[1:0], line};
    end

    // ==========================================================
    // common tasks
    task automatic tally_and_finish();
        if (n_fail == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic cmp_word(input string nm, input logic [31:0] e,
                            input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic cmp_bit(input string nm, input logic e, input logic g);
        total_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("wrong value %s exp %b got %b", nm, e, g);
        end
    endtask

    // bounded wait for hready at a rising edge
    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 20);
        if (n >= 20)
        begin
            n_fail++;
            tally_and_finish();
        end
    endtask

    task automatic bus(input logic w, input logic [31:0] a,
                       input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= ops_pkg::HTRANS_NONSEQ;
        haddr  <= a;
        hwrite <= w;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
    endtask

    function automatic logic lvl(input int c, input logic p, input logic f);
        case (c)
            0:       lvl = f;
            3, 5:    lvl = !p;
            6:       lvl = 1'b0;
            7:       lvl = 1'b1;
            default: lvl = p;
        endcase
    endfunction

    // ==========================================================
    // scenarios
    task automatic t_reset_values();
        cmp_word("step", 32'h8, {28'h0, rx_term_step});
        cmp_bit("hresp", 1'b0, hresp);
        cmp_bit("hreadyout", 1'b1, hreadyout);
        bus(1'b0, A_TERM, 32'h0);
        cmp_word("term", 32'h0410, q);
        bus(1'b0, A_LED, 32'h0);
        cmp_word("led", 32'h0, q);
        bus(1'b0, A_CKO, 32'h0);
        cmp_word("cko", 32'h1, q);
        bus(1'b0, A_NONE, 32'h0);
        cmp_word("unmapped", 32'h0, q);
    endtask

    // every step, read straight after the write
    task automatic t_term_steps();
        logic [31:0] v;
        for (int s = 0; s < 16; s++)
        begin
            v = {16'h0, 11'h5A5, s[3:0], s[0]};
            bus(1'b1, A_TERM, v);
            bus(1'b0, A_TERM, 32'h0);
            cmp_word("term", v, q);
            cmp_word("step", {28'h0, s[3:0]},
                     {28'h0, rx_term_step});
        end
    endtask

    task automatic t_reserved();
        bus(1'b1, A_LED, 32'hFFFF_FFFF);
        bus(1'b0, A_LED, 32'h0);
        cmp_word("led", 32'h7777, q);
        bus(1'b1, A_CKO, 32'hFFFF_FFFF);
        bus(1'b0, A_CKO, 32'h0);
        cmp_word("cko", 32'h00F7, q);
        bus(1'b1, A_NONE, 32'hFFFF);
        bus(1'b0, A_TERM, 32'h0);
        cmp_word("term", {16'h0, 11'h5A5, 4'hF, 1'b1}, q);
    endtask

    // every source code except the clock code on all three pins, clock selects set but unused
    task automatic t_codes();
        logic [2:0] c;
        for (int i = 0; i < 16; i++)
        begin
            c = i[3:1];
            if (c != 3'h1)
            begin
                srcs <= {i[0], !i[0], i[0], !i[0]};
                func <= {i[0], !i[0], i[0]};
                bus(1'b1, A_LED, {17'h0, 3'h1, 1'b0, c, 1'b0, 3'h1, 1'b0, c});
                bus(1'b1, A_CKO, {24'h0, 4'h1, 1'b0, c});
                repeat (4) @(posedge clk_sys);
                @(negedge clk_sys);
                for (int k = 0; k < 3; k++)
                    cmp_bit("pin", lvl(c, i[0], func[k]),
                            pins[k]);
                @(posedge clk_sys);
            end
        end
    endtask

    // crystal, line and an unsupported clock select on all pins
    task automatic t_clock_route();
        logic e;
        for (int s = 0; s < 3; s++)
        begin
            bus(1'b1, A_LED, {17'h0, s[2:0], 4'h1, 1'b0, s[2:0], 4'h1});
            bus(1'b1, A_CKO, {24'h0, s[3:0], 4'h1});
            repeat (4) @(posedge clk_sys);
            repeat (24)
            begin
                @(negedge clk_sys);
                e = (s == 0) ? hx[2] : (s == 1) ? hl[2] : 1'b0;
                for (int k = 0; k < 3; k++)
                    cmp_bit("clk pin", e, pins[k]);
            end
            @(posedge clk_sys);
        end
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        n_fail       = 0;
        total_checks = 0;
        resetn       = 1'b0;
        hsel         = 1'b0;
        haddr        = 32'h0;
        htrans       = 2'h0;
        hwrite       = 1'b0;
        hwdata       = 32'h0;
        srcs         = 4'h0;
        func         = 3'h0;
        repeat (3) @(posedge clk_sys);
        resetn <= 1'b1;
        @(posedge clk_sys);
        t_reset_values();
        t_term_steps();
        t_reserved();
        t_codes();
        t_clock_route();
        tally_and_finish();
    end
endmodule

`default_nettype wire

// >>> hdl/ops_pin_mux.sv
// Purpose: one output pin source selector with registered output
// Assumes: all source levels already in the clk_sys domain
// Notes:   a routed clock is a sampled copy, not a clean clock tree path
`default_nettype none

module ops_pin_mux (
    input  wire logic                  clk_sys,
    input  wire logic                  resetn,
    input  wire logic [2:0]            src_sel,
    input  wire logic [3:0]            clk_sel,
    input  wire logic                  func_level,
    input  wire ops_pkg::ops_sources_t src,
    output var  logic                  pin_level
);

    logic st;
    logic next_st;
    logic clk_pick;

    // ==================================================================
    // clock choice; unlisted codes park the pin low
    always_comb
    begin
        clk_pick = 1'b0;
        if (clk_sel == ops_pkg::CLK_SEL_CRYSTAL)
        begin
            clk_pick = src.crystal_input_clock;
        end
        else if (clk_sel == ops_pkg::CLK_SEL_TXLINE)
        begin
            clk_pick = src.transmit_line_clock;
        end
    end

    // ==================================================================
    // source choice; clock select only matters for the clock source
    always_comb
    begin
        next_st = st;
        unique case (ops_pkg::ops_src_t'(src_sel))
            ops_pkg::OPS_SRC_FUNC:      next_st = func_level;
            ops_pkg::OPS_SRC_CLOCK:     next_st = clk_pick;
            ops_pkg::OPS_SRC_WAKE:      next_st = src.wake_indication;
            ops_pkg::OPS_SRC_UNDERVOLT: next_st = src.undervolt_indication;
            ops_pkg::OPS_SRC_TS_TX:     next_st = src.ts_tx_pulse;
            ops_pkg::OPS_SRC_TS_RX:     next_st = src.ts_rx_pulse;
            ops_pkg::OPS_SRC_LOW:       next_st = 1'b0;
            ops_pkg::OPS_SRC_HIGH:      next_st = 1'b1;
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            st <= 1'b0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign pin_level = st;

endmodule

`default_nettype wire

// >>> hdl/ops_sync.sv
// Purpose: two-flop synchroniser for the pin and foreign-clock inputs
// Assumes: inputs are asynchronous levels, sampled on clk_sys
// Notes:   narrow pulses shorter than a clock period may be missed
`default_nettype none

module ops_sync (
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    input  wire ops_pkg::ops_sources_t raw,
    output var  ops_pkg::ops_sources_t synced
);

    ops_pkg::ops_sync_state_t st;
    ops_pkg::ops_sync_state_t next_st;

    // ==================================================================
    // first stage feeds only the second stage
    always_comb
    begin
        next_st        = st;
        next_st.stage1 = raw;
        next_st.stage2 = st.stage1;
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign synced = st.stage2;

endmodule

`default_nettype wire

// >>> hdl/ops_top.sv
// Purpose: output pin select and receive pad termination control
// Assumes: AHB-Lite slave, zero wait states, word transfers only
// Notes:   register index times four gives the byte address
`default_nettype none

module ops_top (
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // asynchronous sources
    input  wire logic        crystal_input_clock,
    input  wire logic        transmit_line_clock,
    input  wire logic        wake_indication,
    input  wire logic        undervolt_indication,
    input  wire logic        ts_tx_pulse,
    input  wire logic        ts_rx_pulse,
    // indicator functions, same clock domain
    input  wire logic        first_indicator_function,
    input  wire logic        second_indicator_function,
    input  wire logic        third_indicator_function,
    // pins
    output logic             first_indicator_pin,
    output logic             second_indicator_pin,
    output logic             clock_output_pin,
    output logic [3:0]       rx_term_step
);

    ops_pkg::ops_top_state_t st;
    ops_pkg::ops_top_state_t next_st;
    ops_pkg::ops_sources_t   raw_src;
    ops_pkg::ops_sources_t   sync_src;

    logic                    addr_take;
    logic                    addr_mapped;
    logic [ops_pkg::IDX_W-1:0] addr_index;

    // ==================================================================
    // input synchronisation
    // every pin or foreign clock passes two flops before use
    assign raw_src.crystal_input_clock  = crystal_input_clock;
    assign raw_src.transmit_line_clock  = transmit_line_clock;
    assign raw_src.wake_indication      = wake_indication;
    assign raw_src.undervolt_indication = undervolt_indication;
    assign raw_src.ts_tx_pulse          = ts_tx_pulse;
    assign raw_src.ts_rx_pulse          = ts_rx_pulse;

    ops_sync u_sync (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .raw     (raw_src),
        .synced  (sync_src)
    );

    // ==================================================================
    // address phase decode
    // anything outside the three words reads zero and ignores writes
    assign addr_take  = hsel && hready && (htrans == ops_pkg::HTRANS_NONSEQ);
    assign addr_index = haddr[ops_pkg::IDX_MSB:ops_pkg::IDX_LSB];

    always_comb
    begin
        addr_mapped = 1'b0;
        if ((haddr[31:ops_pkg::IDX_MSB+1] == '0)
            && (haddr[ops_pkg::IDX_LSB-1:0] == '0))
        begin
            addr_mapped = (addr_index == ops_pkg::IDX_TERM)
                       || (addr_index == ops_pkg::IDX_LED_SRC)
                       || (addr_index == ops_pkg::IDX_CLK_SRC);
        end
    end

    // ==================================================================
    // register read view
    // read from the updated copy so a write right before is seen
    function automatic logic [31:0] ops_read(
        input ops_pkg::ops_regs_t       regs,
        input logic [ops_pkg::IDX_W-1:0] index
    );
        logic [31:0] value;
        value = '0;
        if (index == ops_pkg::IDX_TERM)
        begin
            value[15:0] = regs.term;
        end
        else if (index == ops_pkg::IDX_LED_SRC)
        begin
            value[15:0] = regs.led_src & ops_pkg::LED_RW_MASK;
        end
        else if (index == ops_pkg::IDX_CLK_SRC)
        begin
            value[15:0] = regs.clk_src & ops_pkg::CLK_RW_MASK;
        end
        return value;
    endfunction

    // ==================================================================
    // bus state and register update
    always_comb
    begin
        next_st = st;

        // data phase write; reserved read-only bits stay zero
        if (st.dp_valid && st.dp_write)
        begin
            if (st.dp_index == ops_pkg::IDX_TERM)
            begin
                // whole word writable, reserved bits included
                next_st.regs.term = hwdata[15:0] & ops_pkg::TERM_RW_MASK;
            end
            else if (st.dp_index == ops_pkg::IDX_LED_SRC)
            begin
                next_st.regs.led_src =
                    hwdata[15:0] & ops_pkg::LED_RW_MASK;
            end
            else if (st.dp_index == ops_pkg::IDX_CLK_SRC)
            begin
                next_st.regs.clk_src =
                    hwdata[15:0] & ops_pkg::CLK_RW_MASK;
            end
        end

        // address phase capture; read data ready for the data phase
        next_st.dp_valid = addr_take && addr_mapped;
        next_st.dp_write = addr_take && hwrite;
        next_st.dp_index = addr_index;
        // unmapped or misaligned reads return zero, not an aliased word
        if (addr_take && !hwrite)
        begin
            next_st.hrdata = addr_mapped ? ops_read(next_st.regs, addr_index)
                                         : '0;
        end
    end

    // ==================================================================
    // state register
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            st              <= '0;
            st.regs.term    <= ops_pkg::TERM_RST;
            st.regs.led_src <= ops_pkg::LED_RST;
            st.regs.clk_src <= ops_pkg::CLK_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    // zero wait states, never an error
    assign hreadyout = 1'b1;
    assign hresp     = ops_pkg::HRESP_OKAY[0];
    assign hrdata    = st.hrdata;

    // ==================================================================
    // receive pad termination
    // one shared step fans out to data, clock, error and valid pads
    assign rx_term_step =
        st.regs.term[ops_pkg::TERM_MSB:ops_pkg::TERM_LSB];

    // ==================================================================
    // first indicator pin
    ops_pin_mux u_first_pin (
        .clk_sys    (clk_sys),
        .resetn     (resetn),
        .src_sel    (st.regs.led_src[ops_pkg::LED0_SRC_LSB +: 3]),
        .clk_sel    ({1'b0,
                      st.regs.led_src[ops_pkg::LED0_CLK_LSB +: 3]}),
        .func_level (first_indicator_function),
        .src        (sync_src),
        .pin_level  (first_indicator_pin)
    );

    // ==================================================================
    // second indicator pin
    ops_pin_mux u_second_pin (
        .clk_sys    (clk_sys),
        .resetn     (resetn),
        .src_sel    (st.regs.led_src[ops_pkg::LED1_SRC_LSB +: 3]),
        .clk_sel    ({1'b0,
                      st.regs.led_src[ops_pkg::LED1_CLK_LSB +: 3]}),
        .func_level (second_indicator_function),
        .src        (sync_src),
        .pin_level  (second_indicator_pin)
    );

    // ==================================================================
    // clock output pin
    // code 000 here routes the third indicator function
    ops_pin_mux u_clock_pin (
        .clk_sys    (clk_sys),
        .resetn     (resetn),
        .src_sel    (st.regs.clk_src[ops_pkg::CKO_SRC_LSB +: 3]),
        .clk_sel    (st.regs.clk_src[ops_pkg::CKO_CLK_LSB +: 4]),
        .func_level (third_indicator_function),
        .src        (sync_src),
        .pin_level  (clock_output_pin)
    );

endmodule

`default_nettype wire
